/* File: include/ident_pkg.sv */
/*
  Word map, bit positions, sizes and states of the identify responder.
  Assumes nothing of its surroundings; definitions only.
*/
package ident_pkg;
  // ----------------------------------------
  // Block size and index width
  // ----------------------------------------
  localparam int WORD_COUNT = 256;   // Words per parameter block
  localparam int IDX_W = 8;          // Index width
  localparam logic [7:0] IDX_LAST = 8'hFF; // Last word index
  localparam logic [7:0] IDX_ONE = 8'h01;  // Index step
  // ----------------------------------------
  // Word positions
  // ----------------------------------------
  localparam logic [7:0] W_CONFIG = 8'h00;   // General configuration
  localparam logic [7:0] W_CYLS = 8'h01;     // Default cylinders
  localparam logic [7:0] W_HEADS = 8'h03;    // Default heads
  localparam logic [7:0] W_SPT = 8'h06;      // Default sectors per track
  localparam logic [7:0] W_SERIAL = 8'h0A;   // Serial string start
  localparam logic [7:0] W_BUFSZ = 8'h15;    // Buffer size
  localparam logic [7:0] W_LONG = 8'h16;     // Long command extra bytes
  localparam logic [7:0] W_FW = 8'h17;       // Firmware string start
  localparam logic [7:0] W_MODEL = 8'h1B;    // Model string start
  localparam logic [7:0] W_MAXMULT = 8'h2F;  // Multiple transfer limit
  localparam logic [7:0] W_CAPS = 8'h31;     // Capabilities
  localparam logic [7:0] W_PIO = 8'h33;      // PIO mode
  localparam logic [7:0] W_DMA = 8'h34;      // DMA mode
  localparam logic [7:0] W_VALID = 8'h35;    // Validity flags
  localparam logic [7:0] W_CUR_CYLS = 8'h36; // Current cylinders
  localparam logic [7:0] W_CUR_HEADS = 8'h37;// Current heads
  localparam logic [7:0] W_CUR_SPT = 8'h38;  // Current sectors per track
  localparam logic [7:0] W_CUR_CAP = 8'h39;  // Current capacity, low word
  localparam logic [7:0] W_MULTI = 8'h3B;    // Multiple setting
  localparam logic [7:0] W_LBA = 8'h3C;      // Addressable sectors, low word
  localparam logic [7:0] W_MDMA = 8'h3F;     // Multi-word DMA modes
  localparam logic [7:0] W_ADVPIO = 8'h40;   // Advanced PIO modes
  localparam logic [7:0] W_CYC = 8'h41;      // First cycle time word
  localparam logic [7:0] W_VERSION = 8'h50;  // Standard revisions
  localparam logic [7:0] W_MINOR = 8'h51;    // Minor version
  localparam logic [7:0] W_CMDSET = 8'h52;   // Command set support
  // ----------------------------------------
  // String and group lengths in words
  // ----------------------------------------
  localparam int SERIAL_WORDS = 10; // Words 10 to 19 only; word 20 stays zero
  localparam int FW_WORDS = 4;
  localparam int MODEL_WORDS = 20;
  localparam int CYC_WORDS = 4;
  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int B_PACKET = 15;      // Packet device class
  localparam int B_REMOVABLE = 7;    // Removable media
  localparam int B_FIXED = 6;        // Not removable device
  localparam int B_STBY_STD = 13;    // Standard standby timer
  localparam int B_IORDY = 11;       // IORDY supported
  localparam int B_IORDY_DIS = 10;   // IORDY can be disabled
  localparam int B_MULTI_OK = 8;     // Multiple setting valid
  localparam int B_VER_LO = 1;       // First revision flag
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_IRQ, ST_XFER} seq_e;
endpackage : ident_pkg

/* File: hdl/ident_word_mux.sv */
/*
  Builds one parameter word for a given index from the drive's settings.
  Assumes the settings are steady while the block is being filled.
*/
`timescale 1ns/1ps
`default_nettype none
module ident_word_mux
  import ident_pkg::*;
(
  // Word select and result
  input wire logic [ident_pkg::IDX_W-1:0] idx,
  output logic [15:0] word,
  // Identity and geometry
  input wire logic is_packet,
  input wire logic removable,
  input wire logic fixed_dev,
  input wire logic [15:0] cyls,
  input wire logic [15:0] heads,
  input wire logic [15:0] spt,
  input wire logic [ident_pkg::SERIAL_WORDS-1:0][15:0] serial_str,
  input wire logic [ident_pkg::FW_WORDS-1:0][15:0] fw_str,
  input wire logic [ident_pkg::MODEL_WORDS-1:0][15:0] model_str,
  input wire logic [15:0] buf_size,
  input wire logic [15:0] long_bytes,
  input wire logic [15:0] max_multi,
  // Capabilities and modes
  input wire logic stby_std,
  input wire logic iordy_sup,
  input wire logic iordy_dis,
  input wire logic [7:0] pio_mode,
  input wire logic [7:0] dma_mode,
  input wire logic [2:0] valid_flags,
  input wire logic [15:0] cur_cyls,
  input wire logic [15:0] cur_heads,
  input wire logic [15:0] cur_spt,
  input wire logic [31:0] cur_cap,
  input wire logic multi_ok,
  input wire logic [7:0] multi_cur,
  input wire logic [31:0] lba_total,
  input wire logic [7:0] mdma_active,
  input wire logic [7:0] mdma_supp,
  input wire logic [7:0] adv_pio,
  input wire logic [ident_pkg::CYC_WORDS-1:0][15:0] cyc_ns,
  input wire logic [3:0] ata_rev,
  input wire logic [15:0] minor_ver,
  input wire logic [15:0] cmd_sets
);
  import ident_pkg::*;

  // ----------------------------------------
  // Word selection
  // ----------------------------------------
  // Offsets into the strings and cycle group
  logic [7:0] off_ser, off_fw, off_mod, off_cyc;
  assign off_ser = idx - W_SERIAL;
  assign off_fw = idx - W_FW;
  assign off_mod = idx - W_MODEL;
  assign off_cyc = idx - W_CYC;

  // Unlisted and reserved words fall to zero
  always_comb
  begin
    word = 16'h0000;
    if (idx >= W_SERIAL && idx < W_BUFSZ - IDX_ONE)
      word = serial_str[off_ser[3:0]];
    else if (idx >= W_FW && idx < W_MODEL)
      word = fw_str[off_fw[1:0]];
    else if (idx >= W_MODEL && idx < W_MAXMULT)
      word = model_str[off_mod[4:0]];
    else if (idx >= W_CYC && idx < W_CYC + 8'(CYC_WORDS))
      word = cyc_ns[off_cyc[1:0]];
    else
    begin
      case (idx)
        W_CONFIG:
        begin
          word[B_PACKET] = is_packet;
          word[B_REMOVABLE] = removable;
          word[B_FIXED] = fixed_dev;
        end
        W_CYLS: word = cyls;
        W_HEADS: word = heads;
        W_SPT: word = spt;
        W_BUFSZ: word = buf_size;
        W_LONG: word = long_bytes;
        W_MAXMULT: word = max_multi;
        W_CAPS:
        begin
          word[B_STBY_STD] = stby_std;
          word[B_IORDY] = iordy_sup;
          word[B_IORDY_DIS] = iordy_dis;
        end
        W_PIO: word = {pio_mode, 8'h00};
        W_DMA: word = {dma_mode, 8'h00};
        W_VALID: word = {13'h0000, valid_flags};
        W_CUR_CYLS: word = cur_cyls;
        W_CUR_HEADS: word = cur_heads;
        W_CUR_SPT: word = cur_spt;
        W_CUR_CAP: word = cur_cap[15:0];
        W_CUR_CAP + IDX_ONE: word = cur_cap[31:16];
        W_MULTI: word = {7'h00, multi_ok, multi_cur};
        W_LBA: word = lba_total[15:0];
        W_LBA + IDX_ONE: word = lba_total[31:16];
        W_MDMA: word = {mdma_active, mdma_supp};
        W_ADVPIO: word = {8'h00, adv_pio};
        W_VERSION: word = {11'h000, ata_rev, 1'b0};
        W_MINOR: word = minor_ver;
        W_CMDSET: word = cmd_sets;
        default: word = 16'h0000;
      endcase
    end
  end
endmodule : ident_word_mux
`default_nettype wire

/* File: hdl/identify_responder.sv */
/*
  Identify command responder: fills a 256-word flip-flop sector buffer
  with the parameter block, then hands it to the host word by word.
  Assumes cmd_identify and rd_stb come from host interface logic on
  ref_clk, and the drive settings are steady during a fill.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Busy, fill buffer, data request, then interrupt.
// - Reserved bits and words read zero.
// - Word 0: class, removable, non-removable flags.
// - Words 1,3,6 give default geometry.
// - Words 10-19 hold 20-character serial.
// - Word 21 buffer size, 512-byte units.
// - Words 23-26 firmware, 27-46 model.
// - Word 47 multiple-transfer sector limit.
// - Word 49 standby timer and IORDY flags.
// - Words 51,52 upper byte give modes.
// - Word 53 bits 0-2 validate groups.
// - Words 54-58 current geometry and capacity.
// - Word 59 multiple valid flag and count.
// - Words 60-61 total addressable sectors.
// - Word 63 active and supported DMA modes.
// - Word 64 low byte advanced PIO modes.
// - Words 65-68 cycle times in nanoseconds.
// - Word 80 bits 1-4 revision support.
// - Zero or all-ones words mean no reporting.
// - Word 82 one feature flag per bit.
// - Word 22 long command extra bytes.
module identify_responder
  import ident_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command and data port
  input wire logic cmd_identify,
  input wire logic rd_stb,
  output logic [15:0] rd_data,
  // Status
  output logic busy,
  output logic drq,
  output logic intrq,
  // Identity and geometry
  input wire logic is_packet,
  input wire logic removable,
  input wire logic fixed_dev,
  input wire logic [15:0] cyls,
  input wire logic [15:0] heads,
  input wire logic [15:0] spt,
  input wire logic [ident_pkg::SERIAL_WORDS-1:0][15:0] serial_str,
  input wire logic [ident_pkg::FW_WORDS-1:0][15:0] fw_str,
  input wire logic [ident_pkg::MODEL_WORDS-1:0][15:0] model_str,
  input wire logic [15:0] buf_size,
  input wire logic [15:0] long_bytes,
  input wire logic [15:0] max_multi,
  // Capabilities and modes
  input wire logic stby_std,
  input wire logic iordy_sup,
  input wire logic iordy_dis,
  input wire logic [7:0] pio_mode,
  input wire logic [7:0] dma_mode,
  input wire logic [2:0] valid_flags,
  input wire logic [15:0] cur_cyls,
  input wire logic [15:0] cur_heads,
  input wire logic [15:0] cur_spt,
  input wire logic [31:0] cur_cap,
  input wire logic multi_ok,
  input wire logic [7:0] multi_cur,
  input wire logic [31:0] lba_total,
  input wire logic [7:0] mdma_active,
  input wire logic [7:0] mdma_supp,
  input wire logic [7:0] adv_pio,
  input wire logic [ident_pkg::CYC_WORDS-1:0][15:0] cyc_ns,
  input wire logic [3:0] ata_rev,
  input wire logic [15:0] minor_ver,
  input wire logic [15:0] cmd_sets
);
  import ident_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  seq_e state_r, state_nxt;           // Sequencer
  logic [IDX_W-1:0] idx_r, idx_nxt;   // Fill and read pointer
  logic busy_r, busy_nxt;             // Busy flag
  logic drq_r, drq_nxt;               // Data request flag
  logic irq_r, irq_nxt;               // Interrupt line
  logic [15:0] rdat_r, rdat_nxt;      // Data port word
  logic [15:0] buf_r [WORD_COUNT];    // Sector buffer
  logic [15:0] buf_nxt [WORD_COUNT];  // Buffer next values
  logic [15:0] fill_word;             // Word built for idx_r
  logic fill_wr;                      // Buffer write this cycle
  logic rd_take;                      // Host read accepted

  assign fill_wr = (state_r == ST_FILL);
  assign rd_take = (state_r == ST_XFER) && rd_stb;

  // ----------------------------------------
  // Word builder
  // ----------------------------------------
  // Filling from a builder, not a stored image, keeps settings live
  ident_word_mux u_mux (
    .idx(idx_r),
    .word(fill_word),
    .is_packet(is_packet),
    .removable(removable),
    .fixed_dev(fixed_dev),
    .cyls(cyls),
    .heads(heads),
    .spt(spt),
    .serial_str(serial_str),
    .fw_str(fw_str),
    .model_str(model_str),
    .buf_size(buf_size),
    .long_bytes(long_bytes),
    .max_multi(max_multi),
    .stby_std(stby_std),
    .iordy_sup(iordy_sup),
    .iordy_dis(iordy_dis),
    .pio_mode(pio_mode),
    .dma_mode(dma_mode),
    .valid_flags(valid_flags),
    .cur_cyls(cur_cyls),
    .cur_heads(cur_heads),
    .cur_spt(cur_spt),
    .cur_cap(cur_cap),
    .multi_ok(multi_ok),
    .multi_cur(multi_cur),
    .lba_total(lba_total),
    .mdma_active(mdma_active),
    .mdma_supp(mdma_supp),
    .adv_pio(adv_pio),
    .cyc_ns(cyc_ns),
    .ata_rev(ata_rev),
    .minor_ver(minor_ver),
    .cmd_sets(cmd_sets)
  );

  // ----------------------------------------
  // Sector buffer
  // ----------------------------------------
  // One entry per word, written only while filling
  for (genvar i = 0; i < WORD_COUNT; i++)
  begin : g_buf
    always_comb
    begin
      buf_nxt[i] = buf_r[i];
      if (fill_wr && idx_r == IDX_W'(i))
        buf_nxt[i] = fill_word;
    end

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        buf_r[i] <= 16'h0000;
      else
        buf_r[i] <= buf_nxt[i];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Next values for control and data port
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    busy_nxt = busy_r;
    drq_nxt = drq_r;
    irq_nxt = irq_r;
    rdat_nxt = rdat_r;
    case (state_r)
      // Waiting; a new command is only taken here
      ST_IDLE:
      begin
        if (cmd_identify)
        begin
          busy_nxt = 1'b1;
          idx_nxt = '0;
          state_nxt = ST_FILL;
        end
      end
      // One word per cycle into the buffer
      ST_FILL:
      begin
        idx_nxt = idx_r + IDX_ONE;
        if (idx_r == IDX_LAST)
        begin
          busy_nxt = 1'b0;
          drq_nxt = 1'b1;
          state_nxt = ST_IRQ;
        end
      end
      // Interrupt one cycle after the data request
      ST_IRQ:
      begin
        irq_nxt = 1'b1;
        state_nxt = ST_XFER;
      end
      // Host drains the block through the data port
      ST_XFER:
      begin
        if (rd_take)
        begin
          rdat_nxt = buf_r[idx_r];
          idx_nxt = idx_r + IDX_ONE;
          irq_nxt = 1'b0;
          if (idx_r == IDX_LAST)
          begin
            drq_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        busy_nxt = 1'b0;
        drq_nxt = 1'b0;
        irq_nxt = 1'b0;
      end
    endcase
  end

  // Register control and data port
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      idx_r <= '0;
      busy_r <= 1'b0;
      drq_r <= 1'b0;
      irq_r <= 1'b0;
      rdat_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      busy_r <= busy_nxt;
      drq_r <= drq_nxt;
      irq_r <= irq_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Outputs straight from flops
  assign busy = busy_r;
  assign drq = drq_r;
  assign intrq = irq_r;
  assign rd_data = rdat_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Command taken, then handoff of request and interrupt
  sequence s_take;
    state_r == ST_IDLE && cmd_identify;
  endsequence

  sequence s_handoff;
    $rose(drq_r) && !busy_r && !irq_r ##1 irq_r && drq_r;
  endsequence

  // Busy at once, request 257 cycles on, interrupt after
  a_cmd_order: assert property (s_take |=> busy_r ##256 s_handoff)
    else $error("identify handoff order or timing wrong");

  // Busy holds through the fill without request
  a_fill_busy: assert property (fill_wr |-> busy_r && !drq_r && !irq_r)
    else $error("busy not held during fill");

  // Reserved tail words stay zero
  a_rsvd_zero: assert property (fill_wr && idx_r > W_CMDSET |-> fill_word == 16'h0000)
    else $error("reserved word not zero");

  // Class and media flags in word 0
  a_config_word: assert property (fill_wr && idx_r == W_CONFIG |=>
    buf_r[0] == {is_packet, 7'h00, removable, fixed_dev, 6'h00})
    else $error("configuration word wrong");

  // Head count lands in its slot
  a_geom_word: assert property (fill_wr && idx_r == W_HEADS |=> buf_r[3] == $past(heads))
    else $error("head count word wrong");

  // First serial word upper byte is first character
  a_serial_word: assert property (fill_wr && idx_r == W_SERIAL |-> fill_word == serial_str[0])
    else $error("serial word wrong");

  // Capability flags only in their bits
  a_caps_word: assert property (fill_wr && idx_r == W_CAPS |->
    fill_word == ({15'h0000, stby_std} << B_STBY_STD
    | {15'h0000, iordy_sup} << B_IORDY | {15'h0000, iordy_dis} << B_IORDY_DIS))
    else $error("capability word wrong");

  // Multiple setting word layout
  a_multi_word: assert property (fill_wr && idx_r == W_MULTI |->
    fill_word[15:9] == 7'h00 && fill_word[B_MULTI_OK] == multi_ok)
    else $error("multiple setting word wrong");

  // Revision word: reserved bit 0 zero, bits 1-4 match ata_rev
  a_rev_word: assert property (fill_wr && idx_r == W_VERSION |->
    fill_word[0] == 1'b0 && fill_word[B_VER_LO +: 4] == ata_rev)
    else $error("revision word wrong");

  // Each read returns the addressed buffer word next cycle
  a_read_data: assert property (rd_take |=> rd_data == buf_r[$past(idx_r)])
    else $error("read data mismatch");

  // Request drops and block ends on the last read
  a_last_read: assert property (rd_take && idx_r == IDX_LAST |=>
    !drq_r && state_r == ST_IDLE)
    else $error("request not cleared after last word");

  // Request stays up until the last word
  a_drq_hold: assert property (rd_take && idx_r != IDX_LAST |=> drq_r)
    else $error("request dropped early");
endmodule : identify_responder
`default_nettype wire

/* File: sim/host_reader.sv */
/*
  Host adapter model: waits for the interrupt, then reads the whole block.
  Assumes the responder's ports on ref_clk; slow mode adds gaps and stray strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module host_reader
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Mode and device status
  input wire logic slow,
  input wire logic busy,
  input wire logic intrq,
  input wire logic [15:0] rd_data,
  // Data port and captured words
  output logic rd_stb,
  output logic got_vld,
  output logic [15:0] got_word
);
  int seed = 32'he226; // Own random stream for gaps
  int left = 0;        // Words still to read
  logic act = 1'b0;    // Transfer phase seen
  logic cap = 1'b0;    // Read taken, data due next edge
  // --------------------------------
  // Read sequencer
  // --------------------------------
  // Data is taken one edge after the strobe, never in the strobe's own step
  always @(posedge ref_clk)
  begin
    got_vld <= cap;
    if (cap) got_word <= rd_data;
    cap <= rd_stb && act;
    if (rd_stb && act) left = left - 1;
    if (act && left == 0) act = 1'b0;
    if (!act && intrq && left == 0)
    begin
      act = 1'b1;
      left = 256;
    end
    if (!rst_n)
    begin
      act = 1'b0;
      left = 0;
    end
    // Stray strobes while busy must be ignored by the device
    rd_stb <= (act && (!slow || ($random(seed) % 3 == 0))) || (slow && busy);
  end
endmodule : host_reader
`default_nettype wire

/* File: sim/test_identify_parameter_responder.sv */
/*
  Self-checking bench: random drive settings, identify runs, word-by-word compare.
  Assumes the responder and the host_reader model; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module test_identify_parameter_responder;
  import ident_pkg::*;
  // --------------------------------
  // Signals
  // --------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_identify = 1'b0;
  logic rd_stb, busy, drq, intrq, got_vld, slow = 1'b0;
  logic [15:0] rd_data, got_word;
  logic is_packet = 1'b0, removable = 1'b0, fixed_dev = 1'b0;
  logic stby_std = 1'b0, iordy_sup = 1'b0, iordy_dis = 1'b0, multi_ok = 1'b0;
  logic [15:0] cyls = 16'h0, heads = 16'h0, spt = 16'h0, buf_size = 16'h0, long_bytes = 16'h0;
  logic [15:0] max_multi = 16'h0, cur_cyls = 16'h0, cur_heads = 16'h0, cur_spt = 16'h0;
  logic [15:0] minor_ver = 16'h0, cmd_sets = 16'h0;
  logic [SERIAL_WORDS-1:0][15:0] serial_str = '0;
  logic [FW_WORDS-1:0][15:0] fw_str = '0;
  logic [MODEL_WORDS-1:0][15:0] model_str = '0;
  logic [CYC_WORDS-1:0][15:0] cyc_ns = '0;
  logic [7:0] pio_mode = 8'h0, dma_mode = 8'h0, multi_cur = 8'h0;
  logic [7:0] mdma_active = 8'h0, mdma_supp = 8'h0, adv_pio = 8'h0;
  logic [2:0] valid_flags = 3'h0;
  logic [3:0] ata_rev = 4'h0;
  logic [31:0] cur_cap = 32'h0, lba_total = 32'h0;
  logic [15:0] exp_w [256]; // Behavioural block image
  int seed = 32'he226;
  int num_errors = 0;
  int num_checks = 0;
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  identify_responder i_dut (.*);
  host_reader i_host (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .busy(busy), .intrq(intrq),
    .rd_data(rd_data), .rd_stb(rd_stb), .got_vld(got_vld), .got_word(got_word));
  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // New random settings at an edge; zero_sets clears command set reporting
  task automatic rand_cfg(input bit zero_sets);
    int k;
    @(posedge ref_clk);
    {is_packet, removable, fixed_dev, stby_std} <= 4'($random(seed));
    {iordy_sup, iordy_dis, multi_ok, valid_flags, ata_rev} <= 10'($random(seed));
    {cyls, heads} <= $random(seed);
    {spt, buf_size} <= $random(seed);
    {long_bytes, max_multi} <= $random(seed);
    {cur_cyls, cur_heads} <= $random(seed);
    {cur_spt, minor_ver} <= $random(seed);
    {pio_mode, dma_mode, multi_cur, adv_pio} <= $random(seed);
    {mdma_active, mdma_supp} <= 16'($random(seed));
    cur_cap <= $random(seed);
    lba_total <= $random(seed);
    cmd_sets <= zero_sets ? 16'h0000 : 16'($random(seed));
    for (k = 0; k < SERIAL_WORDS; k++) serial_str[k] <= 16'($random(seed));
    for (k = 0; k < MODEL_WORDS; k++) model_str[k] <= 16'($random(seed));
    for (k = 0; k < FW_WORDS; k++) fw_str[k] <= 16'($random(seed));
    for (k = 0; k < CYC_WORDS; k++) cyc_ns[k] <= 16'($random(seed));
    #1;
  endtask : rand_cfg
  // Word image from the settings; everything not listed stays zero
  task automatic build_exp();
    int k;
    for (k = 0; k < 256; k++) exp_w[k] = 16'h0000;
    exp_w[0] = {is_packet, 7'h00, removable, fixed_dev, 6'h00};
    exp_w[1] = cyls;
    exp_w[3] = heads;
    exp_w[6] = spt;
    for (k = 0; k < SERIAL_WORDS; k++) exp_w[10 + k] = serial_str[k];
    exp_w[21] = buf_size;
    exp_w[22] = long_bytes;
    for (k = 0; k < 4; k++) exp_w[23 + k] = fw_str[k];
    for (k = 0; k < 20; k++) exp_w[27 + k] = model_str[k];
    exp_w[47] = max_multi;
    exp_w[49] = {2'b00, stby_std, 1'b0, iordy_sup, iordy_dis, 10'h000};
    exp_w[51] = {pio_mode, 8'h00};
    exp_w[52] = {dma_mode, 8'h00};
    exp_w[53] = {13'h0000, valid_flags};
    exp_w[54] = cur_cyls;
    exp_w[55] = cur_heads;
    exp_w[56] = cur_spt;
    {exp_w[58], exp_w[57]} = cur_cap;
    exp_w[59] = {7'h00, multi_ok, multi_cur};
    {exp_w[61], exp_w[60]} = lba_total;
    exp_w[63] = {mdma_active, mdma_supp};
    exp_w[64] = {8'h00, adv_pio};
    for (k = 0; k < 4; k++) exp_w[65 + k] = cyc_ns[k];
    exp_w[80] = {11'h000, ata_rev, 1'b0};
    exp_w[81] = minor_ver;
    exp_w[82] = cmd_sets;
  endtask : build_exp
  // --------------------------------
  // One identify run
  // --------------------------------
  // Slow runs also fire commands while busy and mid-transfer, which must be ignored
  task automatic run(input bit s, input bit zero_sets);
    int n;
    int k;
    int j;
    rand_cfg(zero_sets);
    build_exp();
    slow <= s;
    @(posedge ref_clk);
    cmd_identify <= 1'b1;
    @(posedge ref_clk);
    cmd_identify <= 1'b0;
    #1;
    n = 1;
    check(16'(busy), 16'h0001);
    while (drq !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      cmd_identify <= s && (n == 4);
      #1;
      n++;
    end
    check(16'(n), 16'h0101);
    check(16'({busy, intrq}), 16'h0000);
    @(posedge ref_clk);
    #1;
    check(16'({intrq, drq}), 16'h0003);
    for (k = 0; k < 256; k++)
    begin
      j = 0;
      while (got_vld !== 1'b1 && j < 50)
      begin
        @(posedge ref_clk);
        #1;
        j++;
      end
      if (j >= 50)
      begin
        num_errors++;
        close_out();
      end
      check(got_word, exp_w[k]);
      if (k == 0) check(16'(intrq), 16'h0000);
      @(posedge ref_clk);
      // One stray command pulse mid-transfer in slow runs; cleared at the next word
      cmd_identify <= s && (k == 100);
      #1;
    end
    check(16'({busy, drq, intrq}), 16'h0000);
  endtask : run
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check(16'({busy, drq, intrq}), 16'h0000);
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    run(1'b0, 1'b1);
    run(1'b1, 1'b1);
    close_out();
  end
endmodule : test_identify_parameter_responder
`default_nettype wire
